//--- hw/abs_pkg.sv
// constants and types shared by the adapter bus slave response logic
package abs_pkg;

  // ************************************************************
  // bus pin vector layout after synchronising
  // ************************************************************
  localparam int PIN_COUNT = 11;
  localparam int PIN_CMD = 10;
  localparam int PIN_ADL = 9;
  localparam int PIN_MEMIO = 8;
  localparam int PIN_S0 = 7;
  localparam int PIN_S1 = 6;
  localparam int PIN_ADDR_HI = 5;
  localparam int PIN_ADDR_LO = 3;
  localparam int PIN_SETUP = 2;
  localparam int PIN_REFRESH = 1;
  localparam int PIN_CHANNEL_RESET = 0;
  // idle levels of the bus pins: strobes high, reset low
  localparam logic [PIN_COUNT-1:0] PIN_IDLE_VALUE = 11'h606;

  // ************************************************************
  // cycle status codes {memory-or-io, status 0, status 1}
  // ************************************************************
  localparam logic [2:0] CODE_IO_WRITE = 3'h1;
  localparam logic [2:0] CODE_IO_READ = 3'h2;
  localparam logic [2:0] CODE_MEM_WRITE = 3'h5;
  localparam logic [2:0] CODE_MEM_READ = 3'h6;
  localparam logic [2:0] CODE_RESET_VALUE = 3'h0;
  localparam logic [2:0] ADDR_RESET_VALUE = 3'h0;
  localparam logic [1:0] MODE_RESET_VALUE = 2'h0;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_ADDR,
    CYC_CMD
  } abs_cycle_state_type;

  function automatic logic abs_code_valid(input logic [2:0] code);
    return (code == CODE_IO_WRITE) || (code == CODE_IO_READ) ||
           (code == CODE_MEM_WRITE) || (code == CODE_MEM_READ);
  endfunction : abs_code_valid

endpackage : abs_pkg

//--- hw/abs_ready_if.sv
// signals between the cycle decoder and the ready generator
`timescale 1ns/1ps
`default_nettype none
interface abs_ready_if;
  logic cycleActive;
  logic cycleStart;
  logic syncMode;
  logic clear;
  logic readyStrobe;
  logic adapterReady;
  logic readyOut;

  modport ctl (
    output cycleActive, cycleStart, syncMode, clear, readyStrobe, adapterReady,
    input readyOut
  );
  modport gen (
    input cycleActive, cycleStart, syncMode, clear, readyStrobe, adapterReady,
    output readyOut
  );
endinterface : abs_ready_if
`default_nettype wire

//--- hw/abs_ready_gen.sv
// card ready generation in asynchronous and synchronous extended modes
`timescale 1ns/1ps
`default_nettype none
module abs_ready_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // link to the cycle decoder
  abs_ready_if.gen rdy
);

  logic waitReg;
  logic waitNext;
  logic readyReg;
  logic readyNext;

  // ************************************************************
  // ready state
  // ************************************************************
  always_comb begin
    waitNext = waitReg;
    if (rdy.clear || !rdy.cycleActive) begin
      waitNext = 1'b0;
    end else if (rdy.syncMode && rdy.cycleStart) begin
      waitNext = 1'b1;
    end else if (rdy.readyStrobe && rdy.adapterReady) begin
      waitNext = 1'b0;
    end
    // async mode simply follows the adapter; sync mode holds until strobed
    if (rdy.syncMode) begin
      readyNext = !waitNext;
    end else begin
      readyNext = !(rdy.cycleActive && !rdy.adapterReady);
    end
    if (rdy.clear) begin
      readyNext = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      waitReg <= 1'b0;
      readyReg <= 1'b1;
    end else begin
      waitReg <= waitNext;
      readyReg <= readyNext;
    end
  end

  assign rdy.readyOut = readyReg;

  // ************************************************************
  // checks
  // ************************************************************
  sequence syncStart;
    rdy.syncMode && rdy.cycleStart && !rdy.clear;
  endsequence

  a_sync_extend_start: assert property (@(posedge ref_clk) disable iff (!rstn)
    syncStart |=> !rdy.readyOut)
    else $error("sync mode did not extend the cycle");

  a_async_not_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!rdy.syncMode && rdy.cycleActive && !rdy.adapterReady && !rdy.clear) |=> !rdy.readyOut)
    else $error("async mode ignored adapter not ready");

  a_idle_ready_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!rdy.cycleActive) |=> rdy.readyOut)
    else $error("card ready low outside a cycle");

endmodule : abs_ready_gen
`default_nettype wire

//--- hw/abs_bus_slave.sv
// adapter bus slave: cycle decode, strobes, feedback, ready and setup gating
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - command strobe plus latched status gives internal and external strobes
// - feedback driven low when adapter decode, from card select, is true
// - data-size output driven low only for wide-capable slaves, else undriven
// - card ready high by default, low extends the cycle
// - card ready derived from ready strobe and adapter ready inputs
// - asynchronous or synchronous extended ready mode chosen by option bit
// - low three address bits latched and select the setup register
// - channel reset returns the cycle, latch and response registers to their idle values
// - multi-function pin mode fixed at channel reset
// - setup register access allowed only while setup select is low
// - setup register access blocked while setup select is high
// - no feedback while refresh is low
// - both buffer enables inactive while refresh is low
// - channel check cleared by channel reset
// - status codes 001,010,101,110 valid, others reserved, latched with strobe
module abs_bus_slave import abs_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus pins from the system board
  input wire logic cmdStrobeN,
  input wire logic addressLatchStrobeN,
  input wire logic memIo,
  input wire logic statusBitZeroN,
  input wire logic statusBitOneN,
  input wire logic lowAddressBit0,
  input wire logic lowAddressBit1,
  input wire logic lowAddressBit2,
  input wire logic cardSetupSelectN,
  input wire logic refreshN,
  input wire logic channelReset,
  // bus pins to the system board
  output logic cardSelectedFeedbackN,
  output logic cardWideTransferN,
  output logic cardWideTransferOe,
  output logic cardReadyOut,
  output logic channelCheckOutN,
  // adapter logic inputs
  input wire logic cardSelectInN,
  input wire logic wideCapableIn,
  input wire logic readyStrobeIn,
  input wire logic adapterReadyIn,
  input wire logic adapterErrorIn,
  input wire logic dmaCycleIn,
  input wire logic syncReadyModeIn,
  input wire logic [1:0] multiFunctionStrapIn,
  // adapter strobes and buffer controls
  output logic readStrobe,
  output logic writeStrobe,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic bufferEnableHighByteN,
  output logic bufferEnableLowByteN,
  // setup register access
  output logic posReadStrobe,
  output logic posWriteStrobe,
  output logic [2:0] posIndex,
  output logic [1:0] multiFunctionMode
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [PIN_COUNT-1:0] pinVec;
  logic [PIN_COUNT-1:0] pinSync;

  assign pinVec = {cmdStrobeN, addressLatchStrobeN, memIo, statusBitZeroN, statusBitOneN,
                   lowAddressBit2, lowAddressBit1, lowAddressBit0,
                   cardSetupSelectN, refreshN, channelReset};

  // the first stage feeds only the second; everything reads the second
  for (genvar i = 0; i < PIN_COUNT; i++) begin : gSync
    logic metaReg;
    logic metaNext;
    logic syncReg;
    logic syncNext;
    always_comb begin
      metaNext = pinVec[i];
      syncNext = metaReg;
    end
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        metaReg <= PIN_IDLE_VALUE[i];
        syncReg <= PIN_IDLE_VALUE[i];
      end else begin
        metaReg <= metaNext;
        syncReg <= syncNext;
      end
    end
    assign pinSync[i] = syncReg;
  end

  logic cmdS;
  logic adlS;
  logic setupS;
  logic refreshS;
  logic chResetS;
  logic clearAll;
  assign cmdS = pinSync[PIN_CMD];
  assign adlS = pinSync[PIN_ADL];
  assign setupS = pinSync[PIN_SETUP];
  assign refreshS = pinSync[PIN_REFRESH];
  assign chResetS = pinSync[PIN_CHANNEL_RESET];
  assign clearAll = chResetS;

  // ************************************************************
  // cycle tracking and latching
  // ************************************************************
  abs_cycle_state_type stateReg;
  abs_cycle_state_type stateNext;
  logic adlPrevReg;
  logic adlPrevNext;
  logic [2:0] codeReg;
  logic [2:0] codeNext;
  logic [2:0] addrReg;
  logic [2:0] addrNext;
  logic selReg;
  logic selNext;
  logic setupReg;
  logic setupNext;
  logic adlFall;

  assign adlFall = adlPrevReg && !adlS;

  always_comb begin
    stateNext = stateReg;
    adlPrevNext = adlS;
    codeNext = codeReg;
    addrNext = addrReg;
    selNext = selReg;
    setupNext = setupReg;
    if (adlFall) begin
      // status, address and decode captured together at the latch strobe
      codeNext = {pinSync[PIN_MEMIO], pinSync[PIN_S0], pinSync[PIN_S1]};
      addrNext = pinSync[PIN_ADDR_HI:PIN_ADDR_LO];
      selNext = !cardSelectInN;
      setupNext = setupS;
    end
    unique case (stateReg)
      CYC_IDLE: begin
        if (adlFall) begin
          stateNext = CYC_ADDR;
        end
      end
      CYC_ADDR: begin
        if (!cmdS) begin
          stateNext = CYC_CMD;
        end
      end
      CYC_CMD: begin
        if (cmdS) begin
          stateNext = CYC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || clearAll) begin
      stateReg <= CYC_IDLE;
      adlPrevReg <= 1'b1;
      codeReg <= CODE_RESET_VALUE;
      addrReg <= ADDR_RESET_VALUE;
      selReg <= 1'b0;
      setupReg <= 1'b1;
    end else begin
      stateReg <= stateNext;
      adlPrevReg <= adlPrevNext;
      codeReg <= codeNext;
      addrReg <= addrNext;
      selReg <= selNext;
      setupReg <= setupNext;
    end
  end

  // ************************************************************
  // response decode
  // ************************************************************
  logic codeOk;
  logic isRead;
  logic isWrite;
  logic cycleActive;
  logic memSel;
  logic posOk;
  logic dataPhase;

  assign codeOk = abs_code_valid(codeReg);
  assign isRead = codeReg[1:0] == CODE_IO_READ[1:0];
  assign isWrite = codeReg[1:0] == CODE_IO_WRITE[1:0];
  assign cycleActive = stateReg != CYC_IDLE;
  assign dataPhase = stateReg == CYC_CMD;
  // normal slave cycle: selected, valid code, not setup, not DMA, not refresh
  assign memSel = cycleActive && codeOk && selReg && setupReg && !dmaCycleIn && refreshS;
  assign posOk = cycleActive && codeOk && !setupReg && !dmaCycleIn && refreshS;

  logic fbNReg;
  logic fbNNext;
  logic wideOeReg;
  logic wideOeNext;
  logic rdReg;
  logic rdNext;
  logic wrReg;
  logic wrNext;
  logic posRdReg;
  logic posRdNext;
  logic posWrReg;
  logic posWrNext;
  logic bufHiNReg;
  logic bufHiNNext;
  logic bufLoNReg;
  logic bufLoNNext;
  logic chckNReg;
  logic chckNNext;
  logic memSelPrevReg;
  logic memSelPrevNext;

  always_comb begin
    fbNNext = !memSel;
    wideOeNext = memSel && wideCapableIn;
    rdNext = dataPhase && memSel && isRead;
    wrNext = dataPhase && memSel && isWrite;
    posRdNext = dataPhase && posOk && isRead;
    posWrNext = dataPhase && posOk && isWrite;
    // setup registers are byte wide so only the low lane opens for them
    bufLoNNext = !((rdNext || wrNext || posRdNext || posWrNext) && refreshS);
    bufHiNNext = !((rdNext || wrNext) && wideCapableIn && refreshS);
    // sticky: a serious fault stays reported until the channel is reset
    chckNNext = chckNReg && !adapterErrorIn;
    // remembers last clock's qualification so a cycle start is seen once
    memSelPrevNext = memSel;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn || clearAll) begin
      fbNReg <= 1'b1;
      wideOeReg <= 1'b0;
      rdReg <= 1'b0;
      wrReg <= 1'b0;
      posRdReg <= 1'b0;
      posWrReg <= 1'b0;
      bufHiNReg <= 1'b1;
      bufLoNReg <= 1'b1;
      chckNReg <= 1'b1;
      memSelPrevReg <= 1'b0;
    end else begin
      fbNReg <= fbNNext;
      wideOeReg <= wideOeNext;
      rdReg <= rdNext;
      wrReg <= wrNext;
      posRdReg <= posRdNext;
      posWrReg <= posWrNext;
      bufHiNReg <= bufHiNNext;
      bufLoNReg <= bufLoNNext;
      chckNReg <= chckNNext;
      memSelPrevReg <= memSelPrevNext;
    end
  end

  // ************************************************************
  // multi-function pin mode, caught while channel reset is high
  // ************************************************************
  logic [1:0] modeReg;
  logic [1:0] modeNext;

  always_comb begin
    modeNext = chResetS ? multiFunctionStrapIn : modeReg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      modeReg <= MODE_RESET_VALUE;
    end else begin
      modeReg <= modeNext;
    end
  end

  // ************************************************************
  // ready generator
  // ************************************************************
  abs_ready_if rdyIf ();

  assign rdyIf.cycleActive = memSel;
  assign rdyIf.cycleStart = memSel && (stateReg == CYC_ADDR) && !memSelPrevReg;
  assign rdyIf.syncMode = syncReadyModeIn;
  assign rdyIf.clear = clearAll;
  assign rdyIf.readyStrobe = readyStrobeIn;
  assign rdyIf.adapterReady = adapterReadyIn;

  abs_ready_gen uReady (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .rdy(rdyIf.gen)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign cardSelectedFeedbackN = fbNReg;
  assign cardWideTransferN = !wideOeReg;
  assign cardWideTransferOe = wideOeReg;
  assign cardReadyOut = rdyIf.readyOut;
  assign channelCheckOutN = chckNReg;
  assign readStrobe = rdReg;
  assign writeStrobe = wrReg;
  assign readStrobeN = !rdReg;
  assign writeStrobeN = !wrReg;
  assign bufferEnableHighByteN = bufHiNReg;
  assign bufferEnableLowByteN = bufLoNReg;
  assign posReadStrobe = posRdReg;
  assign posWriteStrobe = posWrReg;
  assign posIndex = addrReg;
  assign multiFunctionMode = modeReg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_refresh_no_feedback: assert property (!refreshS |=> cardSelectedFeedbackN)
    else $error("feedback driven during refresh");
  a_refresh_buf_idle: assert property (!refreshS |=> bufferEnableHighByteN && bufferEnableLowByteN)
    else $error("buffer enabled during refresh");
  a_setup_high_block: assert property (setupReg |=> !posReadStrobe && !posWriteStrobe)
    else $error("setup access while setup select high");
  a_reserved_no_strobe: assert property ((cycleActive && !codeOk) |=> readStrobeN && writeStrobeN && cardSelectedFeedbackN)
    else $error("reserved code produced a response");
  a_dma_no_feedback: assert property (dmaCycleIn |=> cardSelectedFeedbackN)
    else $error("feedback during DMA cycle");
  a_read_strobe_pair: assert property ((dataPhase && memSel && isRead && !clearAll) |=> readStrobe && !readStrobeN)
    else $error("read strobe missing in data phase");
  a_reset_clears_all: assert property (chResetS |=> channelCheckOutN && !readStrobe && !writeStrobe && !posReadStrobe)
    else $error("channel reset did not clear");
  sequence errHeld;
    adapterErrorIn && !chResetS;
  endsequence
  a_error_check_set: assert property (errHeld |=> !channelCheckOutN ##1 (!channelCheckOutN || $past(chResetS)))
    else $error("adapter error not reported");
  a_addr_latched: assert property ((adlFall && !clearAll) |=> posIndex == $past(pinSync[PIN_ADDR_HI:PIN_ADDR_LO]))
    else $error("address not latched at strobe");
  a_wide_drive_low: assert property (cardWideTransferOe |-> !cardWideTransferN)
    else $error("data size driven high");

endmodule : abs_bus_slave
`default_nettype wire

//--- tb/abs_bus_master_model.sv
// bus master and system board model driving one adapter slot
`timescale 1ns/1ps
`default_nettype none
module abs_bus_master_model (
  // clock and slave response
  input wire logic ref_clk,
  input wire logic cardReadyOut,
  // bus pins driven by the master
  output logic cmdStrobeN,
  output logic addressLatchStrobeN,
  output logic [2:0] cycleCode,
  output logic [2:0] lowAddress,
  output logic cardSetupSelectN,
  output logic refreshN,
  output logic channelReset
);
  initial begin
    cmdStrobeN = 1'h1;
    addressLatchStrobeN = 1'h1;
    cycleCode = 3'h0;
    lowAddress = 3'h0;
    cardSetupSelectN = 1'h1;
    refreshN = 1'h1;
    channelReset = 1'h0;
  end

  // ************************************************************
  // bus cycles
  // ************************************************************
  task automatic bus_cycle(input logic [2:0] code, input logic [2:0] addr, input logic setupN,
                           input logic refN);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    cycleCode = code;
    lowAddress = addr;
    cardSetupSelectN = setupN;
    refreshN = refN;
    addressLatchStrobeN = 1'h0;
    repeat (2) @(posedge ref_clk);
    #1;
    addressLatchStrobeN = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    cmdStrobeN = 1'h0;
    repeat (6) @(posedge ref_clk);
    #1;
    // a real master never ends a cycle that the slave is extending
    while (!cardReadyOut && n < 64) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    cmdStrobeN = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    // released code and address lines float: show their inverse rather than a held value
    cycleCode = ~code;
    lowAddress = ~addr;
    cardSetupSelectN = 1'h1;
    refreshN = 1'h1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : bus_cycle

  task automatic chan_reset(input int cycles);
    @(posedge ref_clk);
    #1;
    channelReset = 1'h1;
    repeat (cycles) @(posedge ref_clk);
    #1;
    channelReset = 1'h0;
  endtask : chan_reset
endmodule : abs_bus_master_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking testbench for the adapter bus slave response logic
`timescale 1ns/1ps
`default_nettype none
module testbench import abs_pkg::*;;
  // ************************************************************
  // signals and instances
  // ************************************************************
  localparam logic [10:0] IDLE_RESP = 11'h53C;
  logic ref_clk = 1'h0;
  logic rstn, cmdStrobeN, addressLatchStrobeN, cardSetupSelectN, refreshN, channelReset;
  logic [2:0] cycleCode, lowAddress, posIndex;
  logic cardSelectInN, wideCapableIn, readyStrobeIn, adapterReadyIn, adapterErrorIn;
  logic dmaCycleIn, syncReadyModeIn;
  logic [1:0] multiFunctionStrapIn, multiFunctionMode;
  logic cardSelectedFeedbackN, cardWideTransferN, cardWideTransferOe, cardReadyOut;
  logic channelCheckOutN, readStrobe, writeStrobe, readStrobeN, writeStrobeN;
  logic bufferEnableHighByteN, bufferEnableLowByteN, posReadStrobe, posWriteStrobe;
  logic [10:0] resp;
  int n_fail = 0;
  int tests_run = 0;

  assign resp = {cardSelectedFeedbackN, cardWideTransferOe, cardWideTransferN, readStrobe,
                 writeStrobe, readStrobeN, writeStrobeN, bufferEnableHighByteN,
                 bufferEnableLowByteN, posReadStrobe, posWriteStrobe};

  always #50 ref_clk = ~ref_clk;

  abs_bus_master_model i_abs_bus_master_model (.ref_clk(ref_clk), .cardReadyOut(cardReadyOut),
    .cmdStrobeN(cmdStrobeN), .addressLatchStrobeN(addressLatchStrobeN), .cycleCode(cycleCode),
    .lowAddress(lowAddress), .cardSetupSelectN(cardSetupSelectN), .refreshN(refreshN),
    .channelReset(channelReset));

  abs_bus_slave i_abs_bus_slave (.ref_clk(ref_clk), .rstn(rstn), .cmdStrobeN(cmdStrobeN),
    .addressLatchStrobeN(addressLatchStrobeN), .memIo(cycleCode[2]),
    .statusBitZeroN(cycleCode[1]), .statusBitOneN(cycleCode[0]),
    .lowAddressBit0(lowAddress[0]), .lowAddressBit1(lowAddress[1]),
    .lowAddressBit2(lowAddress[2]), .cardSetupSelectN(cardSetupSelectN), .refreshN(refreshN),
    .channelReset(channelReset), .cardSelectedFeedbackN(cardSelectedFeedbackN),
    .cardWideTransferN(cardWideTransferN), .cardWideTransferOe(cardWideTransferOe),
    .cardReadyOut(cardReadyOut), .channelCheckOutN(channelCheckOutN),
    .cardSelectInN(cardSelectInN), .wideCapableIn(wideCapableIn),
    .readyStrobeIn(readyStrobeIn), .adapterReadyIn(adapterReadyIn),
    .adapterErrorIn(adapterErrorIn), .dmaCycleIn(dmaCycleIn),
    .syncReadyModeIn(syncReadyModeIn), .multiFunctionStrapIn(multiFunctionStrapIn),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe), .readStrobeN(readStrobeN),
    .writeStrobeN(writeStrobeN), .bufferEnableHighByteN(bufferEnableHighByteN),
    .bufferEnableLowByteN(bufferEnableLowByteN), .posReadStrobe(posReadStrobe),
    .posWriteStrobe(posWriteStrobe), .posIndex(posIndex),
    .multiFunctionMode(multiFunctionMode));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [10:0] exp_resp(input logic fb, input logic wide, input logic rd,
                                            input logic wr, input logic pr, input logic pw);
    // high byte lane only for wide normal accesses; setup uses the low lane
    return {~fb, wide, ~wide, rd, wr, ~rd, ~wr, ~((rd | wr) & wide), ~(rd | wr | pr | pw), pr,
            pw};
  endfunction : exp_resp

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // response sampled mid data phase, then idle and ready afterwards
  task automatic run_access(input logic [2:0] code, input logic [2:0] addr, input logic setupN,
                            input logic refN, input logic [10:0] expect_v);
    fork
      i_abs_bus_master_model.bus_cycle(code, addr, setupN, refN);
      begin
        repeat (10) @(posedge ref_clk);
        #1;
        check(resp, expect_v);
        if (!setupN) check({8'h00, posIndex}, {8'h00, addr});
      end
    join
    repeat (2) @(posedge ref_clk);
    #1;
    check(resp, IDLE_RESP);
    check({10'h000, cardReadyOut}, 11'h001);
  endtask : run_access

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values;
    check(resp, IDLE_RESP);
    check({6'h00, channelCheckOutN, cardReadyOut, posIndex}, 11'h018);
    check({9'h000, multiFunctionMode}, 11'h000);
  endtask : t_reset_values

  task automatic t_codes;
    logic [2:0] code;
    logic rd;
    logic wr;
    for (int c = 0; c < 8; c++) begin
      code = c[2:0];
      wideCapableIn = c[0];
      rd = (code == CODE_IO_READ) || (code == CODE_MEM_READ);
      wr = (code == CODE_IO_WRITE) || (code == CODE_MEM_WRITE);
      run_access(code, code, 1'h1, 1'h1, exp_resp(rd | wr, (rd | wr) & c[0], rd, wr, 1'h0,
                 1'h0));
    end
    wideCapableIn = 1'h0;
  endtask : t_codes

  task automatic t_setup;
    run_access(CODE_IO_READ, 3'h5, 1'h0, 1'h1,
               exp_resp(1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    run_access(CODE_IO_WRITE, 3'h2, 1'h0, 1'h1,
               exp_resp(1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1));
  endtask : t_setup

  task automatic t_refused;
    cardSelectInN = 1'h1;
    run_access(CODE_MEM_READ, 3'h4, 1'h1, 1'h1, IDLE_RESP);
    cardSelectInN = 1'h0;
    dmaCycleIn = 1'h1;
    run_access(CODE_MEM_WRITE, 3'h6, 1'h1, 1'h1, IDLE_RESP);
    dmaCycleIn = 1'h0;
    wideCapableIn = 1'h1;
    run_access(CODE_MEM_READ, 3'h3, 1'h1, 1'h0, IDLE_RESP);
    wideCapableIn = 1'h0;
  endtask : t_refused

  task automatic t_ready(input logic sync);
    syncReadyModeIn = sync;
    adapterReadyIn = sync;
    readyStrobeIn = 1'h0;
    fork
      i_abs_bus_master_model.bus_cycle(CODE_MEM_READ, 3'h1, 1'h1, 1'h1);
      begin
        repeat (10) @(posedge ref_clk);
        #1;
        check({10'h000, cardReadyOut}, 11'h000);
        repeat (3) @(posedge ref_clk);
        #1;
        check({10'h000, cardReadyOut}, 11'h000);
        readyStrobeIn = 1'h1;
        adapterReadyIn = 1'h1;
        repeat (2) @(posedge ref_clk);
        #1;
        check({10'h000, cardReadyOut}, 11'h001);
      end
    join
    readyStrobeIn = 1'h0;
    syncReadyModeIn = 1'h0;
  endtask : t_ready

  task automatic t_check_reset;
    adapterErrorIn = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1;
    adapterErrorIn = 1'h0;
    check({10'h000, channelCheckOutN}, 11'h000);
    multiFunctionStrapIn = 2'h2;
    i_abs_bus_master_model.chan_reset(4);
    repeat (4) @(posedge ref_clk);
    #1;
    multiFunctionStrapIn = 2'h1;
    repeat (4) @(posedge ref_clk);
    #1;
    check({10'h000, channelCheckOutN}, 11'h001);
    check({6'h00, multiFunctionMode, posIndex}, 11'h010);
    check(resp, IDLE_RESP);
  endtask : t_check_reset

  initial begin
    rstn = 1'h0;
    cardSelectInN = 1'h0;
    wideCapableIn = 1'h0;
    readyStrobeIn = 1'h0;
    adapterReadyIn = 1'h1;
    adapterErrorIn = 1'h0;
    dmaCycleIn = 1'h0;
    syncReadyModeIn = 1'h0;
    multiFunctionStrapIn = 2'h0;
    repeat (4) @(posedge ref_clk);
    #1;
    rstn = 1'h1;
    t_reset_values();
    t_codes();
    t_setup();
    t_refused();
    t_ready(1'h0);
    t_ready(1'h1);
    t_setup();
    t_check_reset();
    print_verdict();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
